//--- design/bss_pkg.sv
// Package for the buck start-up and fault sequencer
package bss_pkg;
	// Clock and switching timing
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned CLK_NS = 25;
	localparam int unsigned PERIOD_CYC = 64;
	localparam int unsigned PERIOD_W = 6;
	localparam int unsigned EIGHTH_CYC = PERIOD_CYC / 8;
	localparam int unsigned DUTY_W = 4;
	localparam logic [3:0] DUTY_FULL = 4'h8;
	// Pre-bias stepping
	localparam int unsigned STEP_PULSES = 16;
	localparam logic [3:0] STEP_FIRST = 4'h1;
	// Current sampling
	localparam int unsigned SAMPLE_WIN_NS = 30;
	localparam int unsigned SAMPLE_WIN_CYC = (SAMPLE_WIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned SHORT_DELAY_NS = 40;
	localparam int unsigned SHORT_DELAY_CYC = (SHORT_DELAY_NS + CLK_NS - 1) / CLK_NS;
	// Soft-start ramp: 0.4 mV/us to 1.5 V, 0.1 mV code units
	localparam int unsigned SS_RATE_UV_PER_US = 400;
	localparam int unsigned SS_END_MV = 1500;
	localparam int unsigned SS_W = 15;
	localparam logic [14:0] SS_END_CODE = 15'h3a98;
	localparam int unsigned SS_TICK_CYC = CLK_HZ / 4000000;
	// Hiccup
	localparam int unsigned HICCUP_US = 20480;
	localparam int unsigned HICCUP_CYC = HICCUP_US * (CLK_HZ / 1000000);
	// Gate bias selection
	localparam int unsigned ZC_RUN = 256;
	localparam int unsigned ZC_W = 9;
	// Current limit select strap encodings
	typedef enum logic [1:0] {
		BSS_LIM_LOW = 2'b00,
		BSS_LIM_MID = 2'b01,
		BSS_LIM_HIGH = 2'b10
	} bss_limit_e;
	// Comparator results from the power stage
	typedef struct packed {
		logic supply_ok;
		logic enable_ok;
	} bss_comp_s;
	// Sequencer states
	typedef enum logic [1:0] {
		BSS_OFF = 2'b00,
		BSS_START = 2'b01,
		BSS_RUN = 2'b10,
		BSS_HICCUP = 2'b11
	} bss_state_e;
endpackage

//--- design/bss_sequencer.sv
// Start-up, pre-bias, current limit hiccup and gate bias sequencer
// Operation
// - Drivers off while supply or enable low
// - Ready flag when all valid; starts soft-start
// - Turn on needs enable and supply valid
// - Enable below shutdown threshold turns drivers off
// - Low side off until first high pulse
// - Low side pulse widens in eighths
// - Sixteen pulses per pre-bias step
// - Soft-start ramps 0.4 mV/us to 1.5 V
// - Overcurrent protection active during soft-start
// - Strap selects one of three limits
// - Sample 30 ns window eighth before valley
// - Short low side: sample 40 ns in
// - Sample above limit flags overcurrent
// - Overcurrent: latch flag, zero ramp, hiccup
// - Hiccup end clears flag, restarts soft-start
// - Light load low bias, else high
// - Low bias after 256 consecutive crossings
// - Missed crossing resets count, high bias
// - High bias on turn-on; low when disabled
`timescale 1ns/1ps
module bss_sequencer
	import bss_pkg::*;
#(
	parameter int unsigned HICCUP_CYCLES = bss_pkg::HICCUP_CYC
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Comparators and straps
	input wire bss_pkg::bss_comp_s comp,
	input wire bss_pkg::bss_limit_e current_limit_select,
	input wire logic [3:0] duty_demand,
	input wire logic valley_over_low,
	input wire logic valley_over_mid,
	input wire logic valley_over_high,
	input wire logic neg_crossing,
	input wire logic overvoltage,
	// Drivers and status
	output logic high_side_drive,
	output logic low_side_drive,
	output logic [14:0] soft_start_ref,
	output logic overcurrent_flag,
	output logic power_on_ready,
	output logic gate_bias_high,
	output logic sample_strobe
);
	import bss_pkg::*;

	// ==========================================================
	// Power-on ready
	bss_state_e state_ff;
	bss_state_e nxt_state;
	logic por_ff;
	logic all_ok;
	assign all_ok = comp.supply_ok & comp.enable_ok;

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			por_ff <= 1'b0;
		else
			por_ff <= all_ok;
	end

	// ==========================================================
	// Switching period counter
	logic [PERIOD_W-1:0] phase_ff;
	logic period_end;
	assign period_end = (phase_ff == PERIOD_W'(PERIOD_CYC - 1));

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			phase_ff <= '0;
		else
			phase_ff <= period_end ? '0 : phase_ff + 1'b1;
	end

	// ==========================================================
	// Soft-start ramp
	logic [SS_W-1:0] ss_ff;
	logic [3:0] tick_ff;
	logic ss_done;
	assign ss_done = (ss_ff == SS_END_CODE);

	always_ff @(posedge clock)
	begin
		// The ramp holds its end code in run and only drops in off or hiccup
		if (sys_rst || !por_ff || state_ff == BSS_OFF || state_ff == BSS_HICCUP)
		begin
			ss_ff <= '0;
			tick_ff <= '0;
		end
		else if (tick_ff == 4'(SS_TICK_CYC - 1))
		begin
			tick_ff <= '0;
			if (!ss_done)
				ss_ff <= ss_ff + 1'b1;
		end
		else
			tick_ff <= tick_ff + 1'b1;
	end

	// ==========================================================
	// Overcurrent sampling
	logic [3:0] ls_duty;
	logic [PERIOD_W-1:0] ls_start;
	logic [PERIOD_W-1:0] samp_at;
	logic in_window;
	logic over_sel;
	logic oc_event;
	logic [1:0] win_ff;
	logic active;
	assign active = (state_ff == BSS_START) || (state_ff == BSS_RUN);

	always_comb
	begin
		ls_start = PERIOD_W'(PERIOD_CYC) - PERIOD_W'(ls_duty * EIGHTH_CYC);
		if (ls_duty <= 4'h1)
			samp_at = ls_start + PERIOD_W'(SHORT_DELAY_CYC);
		else
			samp_at = PERIOD_W'(PERIOD_CYC - EIGHTH_CYC - SAMPLE_WIN_CYC);
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			win_ff <= '0;
		else if (phase_ff == samp_at && low_side_drive)
			win_ff <= 2'(SAMPLE_WIN_CYC);
		else if (win_ff != '0)
			win_ff <= win_ff - 1'b1;
	end
	assign in_window = (win_ff != '0);

	always_comb
	begin
		case (current_limit_select)
			BSS_LIM_LOW: over_sel = valley_over_low;
			BSS_LIM_HIGH: over_sel = valley_over_high;
			default: over_sel = valley_over_mid;
		endcase
	end
	// Sampling active in start and run alike
	assign oc_event = in_window & over_sel & low_side_drive & active;

	// ==========================================================
	// Sequencer state machine
	logic [31:0] hic_ff;
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			BSS_OFF: if (por_ff) nxt_state = BSS_START;
			BSS_START: if (oc_event || overvoltage) nxt_state = BSS_HICCUP;
				else if (ss_done) nxt_state = BSS_RUN;
			BSS_RUN: if (oc_event || overvoltage) nxt_state = BSS_HICCUP;
			BSS_HICCUP: if (hic_ff == HICCUP_CYCLES - 1) nxt_state = BSS_START;
			default: nxt_state = BSS_OFF;
		endcase
		if (!por_ff)
			nxt_state = BSS_OFF;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			state_ff <= BSS_OFF;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst || state_ff != BSS_HICCUP)
			hic_ff <= '0;
		else
			hic_ff <= hic_ff + 1;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			overcurrent_flag <= 1'b0;
		else if (oc_event)
			overcurrent_flag <= 1'b1;
		else if (state_ff == BSS_HICCUP && nxt_state != BSS_HICCUP)
			overcurrent_flag <= 1'b0;
	end

	// ==========================================================
	// Pre-bias stepping
	logic first_hs_ff;
	logic [3:0] step_ff;
	logic [4:0] pulse_ff;

	always_ff @(posedge clock)
	begin
		if (sys_rst || !por_ff || !active)
		begin
			first_hs_ff <= 1'b0;
			step_ff <= STEP_FIRST;
			pulse_ff <= '0;
		end
		else
		begin
			// The high pulse ends well before the period end, so watch every cycle
			if (high_side_drive)
				first_hs_ff <= 1'b1;
			if (period_end && first_hs_ff && step_ff < duty_demand)
			begin
				if (pulse_ff == 5'(STEP_PULSES - 1))
				begin
					pulse_ff <= '0;
					step_ff <= step_ff + 1'b1;
				end
				else
					pulse_ff <= pulse_ff + 1'b1;
			end
		end
	end

	always_comb
	begin
		if (!first_hs_ff)
			ls_duty = 4'h0;
		else if (step_ff < duty_demand)
			ls_duty = step_ff;
		else
			ls_duty = duty_demand;
	end

	// ==========================================================
	// Driver outputs
	logic [3:0] hs_duty;
	assign hs_duty = DUTY_FULL - duty_demand;

	always_ff @(posedge clock)
	begin
		if (sys_rst || !all_ok || !active)
		begin
			high_side_drive <= 1'b0;
			low_side_drive <= 1'b0;
		end
		else
		begin
			high_side_drive <= phase_ff < PERIOD_W'(hs_duty * EIGHTH_CYC);
			low_side_drive <= phase_ff >= ls_start && ls_duty != 4'h0;
		end
	end

	// ==========================================================
	// Gate bias selection
	logic [ZC_W-1:0] zc_ff;
	logic ls_prev_ff;
	logic ls_fall;
	assign ls_fall = ls_prev_ff & ~low_side_drive;

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			ls_prev_ff <= 1'b0;
		else
			ls_prev_ff <= low_side_drive;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst || !por_ff)
		begin
			zc_ff <= '0;
			gate_bias_high <= 1'b0;
		end
		else if (state_ff == BSS_OFF)
		begin
			zc_ff <= '0;
			gate_bias_high <= 1'b1;
		end
		else if (ls_fall)
		begin
			if (!neg_crossing)
			begin
				zc_ff <= '0;
				gate_bias_high <= 1'b1;
			end
			else if (zc_ff == ZC_W'(ZC_RUN - 1))
				gate_bias_high <= 1'b0;
			else
				zc_ff <= zc_ff + 1'b1;
		end
	end

	// ==========================================================
	// Registered status outputs
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			soft_start_ref <= '0;
			power_on_ready <= 1'b0;
			sample_strobe <= 1'b0;
		end
		else
		begin
			soft_start_ref <= ss_ff;
			power_on_ready <= por_ff;
			sample_strobe <= in_window;
		end
	end

	// ==========================================================
	// Checks
	property p_drv_off;
		@(posedge clock) disable iff (sys_rst)
		!all_ok |=> !high_side_drive && !low_side_drive;
	endproperty
	a_drv_off: assert property (p_drv_off) else $error("drivers on while invalid");

	property p_por;
		@(posedge clock) disable iff (sys_rst)
		$rose(por_ff) |-> $past(all_ok);
	endproperty
	a_por: assert property (p_por) else $error("ready without valid inputs");

	property p_ls_first;
		@(posedge clock) disable iff (sys_rst)
		!first_hs_ff |=> !low_side_drive;
	endproperty
	a_ls_first: assert property (p_ls_first) else $error("low side before high");

	property p_ss_mono;
		@(posedge clock) disable iff (sys_rst)
		state_ff == BSS_START && $past(state_ff) == BSS_START |-> ss_ff >= $past(ss_ff);
	endproperty
	a_ss_mono: assert property (p_ss_mono) else $error("ramp not rising");

	property p_oc_latch;
		@(posedge clock) disable iff (sys_rst)
		oc_event && por_ff |=> overcurrent_flag && state_ff == BSS_HICCUP;
	endproperty
	a_oc_latch: assert property (p_oc_latch) else $error("overcurrent not latched");

	property p_ovp;
		@(posedge clock) disable iff (sys_rst)
		overvoltage && active && por_ff |=> state_ff == BSS_HICCUP;
	endproperty
	a_ovp: assert property (p_ovp) else $error("overvoltage not acted upon");

	property p_hic_zero;
		@(posedge clock) disable iff (sys_rst)
		state_ff == BSS_HICCUP |=> ss_ff == '0;
	endproperty
	a_hic_zero: assert property (p_hic_zero) else $error("ramp not held low");

	property p_step;
		@(posedge clock) disable iff (sys_rst)
		step_ff != $past(step_ff) && por_ff && $past(active) |->
			$past(pulse_ff) == 5'(STEP_PULSES - 1);
	endproperty
	a_step: assert property (p_step) else $error("step after wrong count");

	property p_bias_miss;
		@(posedge clock) disable iff (sys_rst)
		por_ff && state_ff != BSS_OFF && ls_fall && !neg_crossing |=> gate_bias_high;
	endproperty
	a_bias_miss: assert property (p_bias_miss) else $error("bias not restored");

	property p_por_clear;
		@(posedge clock) disable iff (sys_rst)
		!por_ff |=> step_ff == STEP_FIRST && pulse_ff == '0;
	endproperty
	a_por_clear: assert property (p_por_clear) else $error("counters not cleared");
endmodule

//--- testbench/bss_stage_model.sv
// Behavioural power stage comparators facing the sequencer
`timescale 1ns/1ps
module bss_stage_model
(
	// Load seen by the stage
	input wire logic [1:0] load_level,
	input wire logic light_load,
	// Comparator results
	output logic valley_over_low,
	output logic valley_over_mid,
	output logic valley_over_high,
	output logic neg_crossing
);
	// Each load level lies above that many of the three limits
	assign valley_over_low = (load_level >= 2'h1);
	assign valley_over_mid = (load_level >= 2'h2);
	assign valley_over_high = (load_level == 2'h3);
	assign neg_crossing = light_load;
endmodule

//--- testbench/tb_bss_sequencer.sv
// Self-checking bench for the start-up and fault sequencer
`timescale 1ns/1ps
module tb_bss_sequencer;
	import bss_pkg::*;
	// ====
	// Stimulus and observation
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	bss_comp_s comp = '0;
	bss_limit_e lim = BSS_LIM_LOW;
	logic [1:0] load = 2'h0;
	logic light = 1'b0;
	logic ovp = 1'b0;
	logic vl, vm, vh, nc, hs, ls, oc, rdy, bias, smp;
	logic [14:0] ssr;
	int fail_count = 0;
	int compares = 0;
	int hs_seen = 0;
	int off_cnt = 0;
	int run = 0;
	int widths[$];

	bss_stage_model i_bss_stage_model (.load_level(load), .light_load(light),
		.valley_over_low(vl), .valley_over_mid(vm), .valley_over_high(vh),
		.neg_crossing(nc));
	bss_sequencer #(.HICCUP_CYCLES(200)) i_bss_sequencer (.clock(clock),
		.sys_rst(sys_rst), .comp(comp), .current_limit_select(lim),
		.duty_demand(4'h4), .valley_over_low(vl), .valley_over_mid(vm),
		.valley_over_high(vh), .neg_crossing(nc), .overvoltage(ovp),
		.high_side_drive(hs), .low_side_drive(ls), .soft_start_ref(ssr),
		.overcurrent_flag(oc), .power_on_ready(rdy), .gate_bias_high(bias),
		.sample_strobe(smp));

	initial
	begin
		forever #12.5 clock = ~clock;
	end

	// ====
	// Checks and waits
	task automatic fail(input string msg);
		fail_count++;
		$display("unexpected at %0t: %s", $time, msg);
	endtask

	task automatic chk(input logic got, input logic exp, input string what);
		compares++;
		if (got !== exp)
			fail(what);
	endtask

	task automatic chk_ref(input logic [14:0] lo, input logic [14:0] hi);
		compares++;
		if ((ssr >= lo && ssr <= hi) !== 1'b1)
			fail("ramp value");
	endtask

	function automatic logic pick(input int sel);
		case (sel)
			0: return rdy;
			1: return oc;
			default: return bias;
		endcase
	endfunction

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic wait_on(input int sel, input logic val, input int lim_n);
		int n;
		n = 0;
		while (pick(sel) !== val && n < lim_n)
		begin
			@(negedge clock);
			n++;
		end
		if (n >= lim_n)
		begin
			fail("wait timed out");
			wrap_up();
		end
		else
			chk(pick(sel), val, "wait");
	endtask

	// Low-side pulse widths, first high pulse and lockout watch
	always @(posedge clock)
	begin
		if (!rdy)
			hs_seen <= 0;
		else if (hs)
			hs_seen <= 1;
		if (rdy && ls && hs_seen == 0)
			fail("low side before first high pulse");
		off_cnt <= (comp.supply_ok && comp.enable_ok) ? 0 : off_cnt + 1;
		if (off_cnt > 2 && (hs || ls))
			fail("driver on while locked out");
		if (ls)
			run <= run + 1;
		else if (run > 0)
		begin
			widths.push_back(run);
			run <= 0;
		end
	end

	// ====
	// Scenarios
	task automatic t_start();
		int n;
		n = 0;
		chk(hs | ls | oc | rdy | bias | smp, 1'b0, "outputs after reset");
		chk_ref(15'h0, 15'h0);
		comp.supply_ok = 1'b1;
		repeat (4) @(negedge clock);
		chk(rdy, 1'b0, "ready with enable low");
		chk(bias, 1'b0, "bias while disabled");
		comp.enable_ok = 1'b1;
		wait_on(0, 1'b1, 3);
		repeat (2) @(negedge clock);
		chk(bias, 1'b1, "bias at turn-on");
		repeat (3000) @(negedge clock);
		chk_ref(15'h122, 15'h130);
		chk(widths[0] == EIGHTH_CYC, 1'b1, "first step");
		chk(widths[20] == 2 * EIGHTH_CYC, 1'b1, "second step");
		chk(widths[36] == 3 * EIGHTH_CYC, 1'b1, "third step");
		repeat (PERIOD_CYC)
		begin
			@(negedge clock);
			n += smp;
		end
		chk(n == SAMPLE_WIN_CYC, 1'b1, "sample window length");
		$display("test start done");
	endtask

	task automatic t_ovp();
		ovp = 1'b1;
		repeat (3) @(negedge clock);
		ovp = 1'b0;
		chk(hs | ls | oc, 1'b0, "switching in overvoltage hiccup");
		chk_ref(15'h0, 15'h0);
		repeat (240) @(negedge clock);
		chk(ssr != 15'h0, 1'b1, "ramp restart after overvoltage");
		$display("test overvoltage done");
	endtask

	task automatic t_shutdown();
		comp.enable_ok = 1'b0;
		wait_on(0, 1'b0, 3);
		repeat (2) @(negedge clock);
		chk(hs | ls, 1'b0, "drivers after shutdown");
		chk_ref(15'h0, 15'h0);
		comp.enable_ok = 1'b1;
		wait_on(0, 1'b1, 3);
		$display("test shutdown done");
	endtask

	task automatic t_limit(input bss_limit_e s, input logic [1:0] lv);
		lim = s;
		load = lv;
		repeat (300) @(negedge clock);
		chk(oc, 1'b0, "trip below limit");
		load = lv + 2'h1;
		wait_on(1, 1'b1, 300);
		load = 2'h0;
		repeat (4) @(negedge clock);
		chk_ref(15'h0, 15'h0);
		wait_on(1, 1'b0, 400);
		repeat (40) @(negedge clock);
		chk(ssr != 15'h0, 1'b1, "ramp restart");
		$display("test limit done");
	endtask

	task automatic t_bias();
		light = 1'b1;
		repeat (250 * PERIOD_CYC) @(negedge clock);
		chk(bias, 1'b1, "bias dropped early");
		wait_on(2, 1'b0, 10 * PERIOD_CYC);
		light = 1'b0;
		wait_on(2, 1'b1, 2 * PERIOD_CYC);
		$display("test bias done");
	endtask

	initial
	begin
		repeat (5) @(negedge clock);
		sys_rst = 1'b0;
		@(negedge clock);
		t_start();
		t_shutdown();
		t_limit(BSS_LIM_LOW, 2'h0);
		t_limit(BSS_LIM_MID, 2'h1);
		t_limit(BSS_LIM_HIGH, 2'h2);
		t_ovp();
		t_bias();
		wrap_up();
	end
endmodule
